// *** rtl/aem_top.sv ***
/*
  Alert routing mask with its register slave.
  Holds the enable register that picks which summary alerts drive the
  hardware alert output, the 16-bit chain status vector and the alert packet,
  plus a small sticky event register with a mask for an interrupt line.

  Register map, byte address with word index in brackets:
    0x64 (0x19) alert_route_enable, read-write, reset 0x3FBF; bits 14
                and 6 are reserved, read zero and ignore writes.
    0x6C (0x1B) alert_summary_status, read-only raw status levels.
    0x70 (0x1C) sticky events, write one to clear.
    0x74 (0x1D) event mask, read-write, reset 0x0000.
    0x78 (0x1E) routed view, read-only: chain alerts in [15:0], packet
                alerts in [31:16].
    Every other word reads zero and ignores writes.

  Bus timing: every access takes exactly one wait cycle. The request is
  seen in its first cycle, where read data are captured; the next edge
  is the answer edge, with waitrequest low, where a write lands. Byte
  lanes 2 and 3 have no effect.

  Reset: RESETN is sampled on the rising edge; all enables but the scan
  bit come up set, and the event mask comes up clear.

  Trade-off: the notification outputs come from flip-flops, CHAIN_ALERT_ANY
  from an OR of the chain flops. That costs one clock of latency after a
  status or enable change, but keeps decode glitches off the pin and out
  of the chain and packet logic.

  Limitation: events fire on rising edges of enabled alert-path levels,
  so clearing an enable also stops new events of that alert, and the
  status bits themselves carry no history.

  Assumes: one clock CLK, synchronous active-low RESETN, summary status
  bits arriving as levels synchronous to CLK, and an Avalon-MM master
  with byte addresses that honours waitrequest.

*/
// The Avalon-MM interface to the registers was decided locally.
`default_nettype none
`include "aem_defs.svh"

module aem_top
  import aem_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESETN,

  // Avalon-MM slave.
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,

  // Summary status from the measurement and link logic.
  input wire logic [15:0] ALERT_SUMMARY_STATUS,

  // Notification outputs.
  output logic ALERT_OUT,
  output logic [15:0] CHAIN_ALERTS,
  output logic CHAIN_ALERT_ANY,
  output logic [15:0] PACKET_ALERTS,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // Constants brought to the widths they meet.

  localparam logic [15:0] ENABLE_RST = `AEM_ENABLE_RST;
  localparam logic [15:0] ENABLE_WMASK = `AEM_ENABLE_WMASK;
  localparam logic [15:0] MASK_RST = `AEM_MASK_RST;
  localparam logic [5:0] IDX_ENABLE = `AEM_IDX_ENABLE;
  localparam logic [5:0] IDX_STATUS = `AEM_IDX_STATUS;
  localparam logic [5:0] IDX_EVENT = `AEM_IDX_EVENT;
  localparam logic [5:0] IDX_MASK = `AEM_IDX_MASK;
  localparam logic [5:0] IDX_ROUTED = `AEM_IDX_ROUTED;

  ////////////////////////////////////////////////////////////////////////
  // State, next state and the routing slice.

  aem_state_t s_q;
  aem_state_t s_d;

  aem_route_if rt_if ();

  aem_route u_route (
    .rt (rt_if.route)
  );

  // Working signals of the decode.
  logic req;
  logic commit;
  logic [5:0] idx;
  logic [15:0] wmask16;
  logic [15:0] wdata16;
  logic [15:0] rise;
  logic [15:0] clr;

  ////////////////////////////////////////////////////////////////////////
  // Named enable fields.

  // One name per implemented enable bit, so the readback below spells
  // out the field layout and a reserved bit cannot leak into it.
  logic scan_done_notify_en;
  logic cell_mismatch_notify_en;
  logic cell_over_notify_en;
  logic cell_under_notify_en;
  logic block_over_notify_en;
  logic block_under_notify_en;
  logic aux_over_notify_en;
  logic aux_under_notify_en;
  logic crc_error_notify_en;
  logic link_error_notify_en;
  logic calib_fault_notify_en;
  logic balancing_notify_en;
  logic safety_sum2_notify_en;
  logic safety_sum1_notify_en;
  logic [15:0] enable_view;

  // Field taps of the stored enable word; the bit positions sit in the
  // defs header beside the reset value, so the two cannot drift apart.
  assign scan_done_notify_en = s_q.enable[`AEM_BIT_SCAN];
  assign cell_mismatch_notify_en = s_q.enable[`AEM_BIT_MSMTCH];
  assign cell_over_notify_en = s_q.enable[`AEM_BIT_CELLOV];
  assign cell_under_notify_en = s_q.enable[`AEM_BIT_CELLUV];
  assign block_over_notify_en = s_q.enable[`AEM_BIT_BLKOV];
  assign block_under_notify_en = s_q.enable[`AEM_BIT_BLKUV];
  assign aux_over_notify_en = s_q.enable[`AEM_BIT_AUXOV];
  assign aux_under_notify_en = s_q.enable[`AEM_BIT_AUXUV];
  assign crc_error_notify_en = s_q.enable[`AEM_BIT_CRC];
  assign link_error_notify_en = s_q.enable[`AEM_BIT_LINK];
  assign calib_fault_notify_en = s_q.enable[`AEM_BIT_CALIB];
  assign balancing_notify_en = s_q.enable[`AEM_BIT_BAL];
  assign safety_sum2_notify_en = s_q.enable[`AEM_BIT_SAFE2];
  assign safety_sum1_notify_en = s_q.enable[`AEM_BIT_SAFE1];

  // reserved read zero
  // Bits 14 and 6 are tied low here whatever the stored word holds.
  assign enable_view = {
    scan_done_notify_en,
    1'b0,
    cell_mismatch_notify_en,
    cell_over_notify_en,
    cell_under_notify_en,
    block_over_notify_en,
    block_under_notify_en,
    aux_over_notify_en,
    aux_under_notify_en,
    1'b0,
    crc_error_notify_en,
    link_error_notify_en,
    calib_fault_notify_en,
    balancing_notify_en,
    safety_sum2_notify_en,
    safety_sum1_notify_en
  };

  ////////////////////////////////////////////////////////////////////////
  // Routing inputs.

  assign rt_if.status = ALERT_SUMMARY_STATUS;
  assign rt_if.enable = s_q.enable;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // A request is answered one cycle after it is first seen.
  assign req = AVS_READ | AVS_WRITE;
  assign commit = req & (s_q.phase == AEM_ANSWER);

  // Byte addresses; the low two bits are ignored for aligned words.
  assign idx = AVS_ADDRESS[7:2];

  // Byte lanes 0 and 1 cover every implemented field.
  assign wmask16 = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign wdata16 = AVS_WRITEDATA[15:0];

  // Waitrequest is high from the first cycle until the answer cycle.
  assign AVS_WAITREQUEST = req & (s_q.phase != AEM_ANSWER);

  ////////////////////////////////////////////////////////////////////////
  // Event detection.

  // Events are new enabled alerts on the hardware alert path, so the
  // interrupt follows the same masking software chose for the pin.
  assign rise = rt_if.alert_vec & ~s_q.prev_alert;

  // Write-one-to-clear strobe for the sticky events.
  always_comb begin
    clr = 16'h0000;
    if (commit && AVS_WRITE && idx == IDX_EVENT) begin
      clr = wdata16 & wmask16;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_d = s_q;

    // Phase walks idle to answer and back, one answer per request.
    case (s_q.phase)
      AEM_IDLE: begin
        if (req) begin
          s_d.phase = AEM_ANSWER;
        end
      end
      AEM_ANSWER: begin
        s_d.phase = AEM_IDLE;
      end
      default: begin
        s_d.phase = AEM_IDLE;
      end
    endcase

    // Read data is captured in the cycle before the answer, so it
    // stands in a flip-flop at the edge where waitrequest is low.
    if (req && s_q.phase == AEM_IDLE && AVS_READ) begin
      case (idx)
        IDX_ENABLE: begin
          s_d.rdata = {16'h0000, enable_view};
        end
        IDX_STATUS: begin
          s_d.rdata = {16'h0000, ALERT_SUMMARY_STATUS};
        end
        IDX_EVENT: begin
          s_d.rdata = {16'h0000, s_q.event_st};
        end
        IDX_MASK: begin
          s_d.rdata = {16'h0000, s_q.event_mask};
        end
        IDX_ROUTED: begin
          s_d.rdata = {s_q.packet, s_q.chain};
        end
        default: begin
          // Unmapped words read as zero.
          s_d.rdata = 32'h00000000;
        end
      endcase
    end

    // Writes land at the answer edge only; unmapped writes vanish.
    if (commit && AVS_WRITE) begin
      case (idx)
        IDX_ENABLE: begin
          s_d.enable = (s_q.enable & ~wmask16) |
            (wdata16 & wmask16 & ENABLE_WMASK);
        end
        IDX_MASK: begin
          s_d.event_mask = (s_q.event_mask & ~wmask16) |
            (wdata16 & wmask16);
        end
        default: begin
          s_d.enable = s_q.enable;
        end
      endcase
    end

    // A new event in the clearing cycle survives the clear.
    s_d.event_st = (s_q.event_st & ~clr) | rise;
    s_d.prev_alert = rt_if.alert_vec;

    s_d.alert = |rt_if.alert_vec;

    s_d.chain = rt_if.chain_vec;

    s_d.packet = rt_if.packet_vec;

    // Level interrupt while any unmasked sticky event stands.
    s_d.irq = |(s_d.event_st & s_d.event_mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      s_q.phase <= AEM_IDLE;
      s_q.enable <= ENABLE_RST;
      s_q.event_st <= 16'h0000;
      s_q.event_mask <= MASK_RST;
      s_q.prev_alert <= 16'h0000;
      s_q.chain <= 16'h0000;
      s_q.packet <= 16'h0000;
      s_q.alert <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.rdata <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops apart from waitrequest and the OR of the chain flops behind CHAIN_ALERT_ANY.

  // Registered outputs trade one cycle of latency for clean levels.
  assign ALERT_OUT = s_q.alert;
  assign CHAIN_ALERTS = s_q.chain;
  assign CHAIN_ALERT_ANY = |s_q.chain;
  assign PACKET_ALERTS = s_q.packet;
  assign IRQ = s_q.irq;
  assign AVS_READDATA = s_q.rdata;

endmodule

`default_nettype wire

// *** rtl/aem_defs.svh ***
/*
  Register offsets, field positions, reset values and path masks of the
  alert routing block. Included by the package and the modules; holds
  definitions only.
*/
`ifndef AEM_DEFS_SVH
`define AEM_DEFS_SVH

// Register indexes; byte address is four times the index.
`define AEM_IDX_ENABLE 6'h19
`define AEM_IDX_STATUS 6'h1B
`define AEM_IDX_EVENT 6'h1C
`define AEM_IDX_MASK 6'h1D
`define AEM_IDX_ROUTED 6'h1E

// Field positions of the enable register.
`define AEM_BIT_SCAN 15
`define AEM_BIT_MSMTCH 13
`define AEM_BIT_CELLOV 12
`define AEM_BIT_CELLUV 11
`define AEM_BIT_BLKOV 10
`define AEM_BIT_BLKUV 9
`define AEM_BIT_AUXOV 8
`define AEM_BIT_AUXUV 7
`define AEM_BIT_CRC 5
`define AEM_BIT_LINK 4
`define AEM_BIT_CALIB 3
`define AEM_BIT_BAL 2
`define AEM_BIT_SAFE2 1
`define AEM_BIT_SAFE1 0

// Reset values.
`define AEM_ENABLE_RST 16'h3FBF
`define AEM_MASK_RST 16'h0000

// Implemented enable bits; 14 and 6 are reserved.
`define AEM_ENABLE_WMASK 16'hBFBF

// Which alerts may reach each notification path.
`define AEM_PATH_ALERT 16'hBFBF
`define AEM_PATH_CHAIN 16'h3F9F
`define AEM_PATH_PACKET 16'h3FBF

// Bus answer latency in cycles after the request is first seen.
`define AEM_BUS_LATENCY 1

`endif

// *** rtl/aem_pkg.sv ***
/*
  Types of the alert routing block.
  Assumes aem_defs.svh is on the include path.
*/
`default_nettype none
`include "aem_defs.svh"

package aem_pkg;

  // Bus slave phase, Gray coded.
  typedef enum logic [1:0] {
    AEM_IDLE = 2'b00,
    AEM_ANSWER = 2'b01
  } aem_phase_t;

  // Whole state of the top module.
  typedef struct packed {
    aem_phase_t phase;
    logic [15:0] enable;
    logic [15:0] event_st;
    logic [15:0] event_mask;
    logic [15:0] prev_alert;
    logic [15:0] chain;
    logic [15:0] packet;
    logic alert;
    logic irq;
    logic [31:0] rdata;
  } aem_state_t;

endpackage

`default_nettype wire

// *** rtl/aem_route_if.sv ***
/*
  Carries status and enables to the routing slice and the routed
  vectors back. Used between aem_top and aem_route only.
*/
`default_nettype none

interface aem_route_if;
  logic [15:0] status;
  logic [15:0] enable;
  logic [15:0] alert_vec;
  logic [15:0] chain_vec;
  logic [15:0] packet_vec;

  modport top (
    output status,
    output enable,
    input alert_vec,
    input chain_vec,
    input packet_vec
  );

  modport route (
    input status,
    input enable,
    output alert_vec,
    output chain_vec,
    output packet_vec
  );
endinterface

`default_nettype wire

// *** rtl/aem_route.sv ***
/*
  Per-alert routing slice: gates each summary status bit by its enable
  and by the paths that alert may take. Purely combinational.
  Assumes the enable word already has reserved bits cleared.
*/
`default_nettype none
`include "aem_defs.svh"

module aem_route
  import aem_pkg::*;
(
  // Routing connection.
  aem_route_if.route rt
);

  localparam logic [15:0] PATH_ALERT = `AEM_PATH_ALERT;
  localparam logic [15:0] PATH_CHAIN = `AEM_PATH_CHAIN;
  localparam logic [15:0] PATH_PACKET = `AEM_PATH_PACKET;

  ////////////////////////////////////////////////////////////////////////
  // One gate per alert and path; the status itself is never altered here.
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      assign rt.alert_vec[i] = rt.status[i] & rt.enable[i] & PATH_ALERT[i];
      assign rt.chain_vec[i] = rt.status[i] & rt.enable[i] & PATH_CHAIN[i];
      assign rt.packet_vec[i] = rt.status[i] & rt.enable[i] &
        PATH_PACKET[i];
    end
  endgenerate

endmodule

`default_nettype wire

// *** testbench/aem_status_src.sv ***
/*
  Behavioural source of the summary status levels seen by the block.
  Assumes the bench drives want by non-blocking assignment on edges.
*/
`default_nettype none

module aem_status_src (
  // Clock and commanded levels.
  input wire logic clk,
  input wire logic [15:0] want,
  // Levels toward the block.
  output logic [15:0] status
);
  timeunit 1ns;
  timeprecision 100ps;

  // Levels move only on an edge, as synchronous sources do.
  always_ff @(posedge clk) begin
    status <= want;
  end
endmodule

`default_nettype wire

// *** testbench/aem_top_properties.sv ***
/*
  Port assertions of the alert routing block.
  Assumes it is bound into aem_top and sees only its ports.
*/
`default_nettype none

module aem_top_properties (
  // Clock, reset and bus handshake.
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // Status in and notifications out.
  input wire logic [15:0] ALERT_SUMMARY_STATUS,
  input wire logic ALERT_OUT,
  input wire logic [15:0] CHAIN_ALERTS,
  input wire logic CHAIN_ALERT_ANY,
  input wire logic [15:0] PACKET_ALERTS,
  input wire logic IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  ////////////////////////////////////////////////////////////////////////
  // Path exclusions hold whatever software writes to the enables.
  a_chain_path: assert property (
    (CHAIN_ALERTS & ~($past(ALERT_SUMMARY_STATUS) & 16'h3F9F)) == 16'h0)
    else $error("Chain alert without a cause.");
  a_packet_path: assert property (
    (PACKET_ALERTS & ~($past(ALERT_SUMMARY_STATUS) & 16'h3FBF)) == 16'h0)
    else $error("Packet alert without a cause.");
  a_chain_in_packet: assert property (
    (CHAIN_ALERTS & ~PACKET_ALERTS) == 16'h0)
    else $error("Chain alert missing from packet.");
  a_chain_any: assert property (
    CHAIN_ALERT_ANY == (CHAIN_ALERTS != 16'h0))
    else $error("Chain summary flag wrong.");
  a_packet_alerts: assert property (
    (PACKET_ALERTS != 16'h0) |-> ALERT_OUT)
    else $error("Alert output low with a packet alert.");
  a_alert_idle: assert property (
    ($past(ALERT_SUMMARY_STATUS) == 16'h0) |-> !ALERT_OUT)
    else $error("Alert output high with no status.");

  ////////////////////////////////////////////////////////////////////////
  // One wait cycle per access, none when idle.
  a_bus_answer: assert property (
    $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("Bus answer not after one wait cycle.");
  a_bus_idle: assert property (
    !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
    else $error("Wait request with no access.");

  // Main scenarios reached.
  c_alert: cover property ($rose(ALERT_OUT));
  c_irq: cover property ($rose(IRQ));
  c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule

bind aem_top aem_top_properties chk (.CLK(CLK), .RESETN(RESETN),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .ALERT_SUMMARY_STATUS(ALERT_SUMMARY_STATUS), .ALERT_OUT(ALERT_OUT),
  .CHAIN_ALERTS(CHAIN_ALERTS), .CHAIN_ALERT_ANY(CHAIN_ALERT_ANY),
  .PACKET_ALERTS(PACKET_ALERTS), .IRQ(IRQ));

`default_nettype wire

// *** testbench/alert_enable_masking_bench.sv ***
/*
  Self-checking bench of the alert routing block.
  Assumes aem_top, aem_status_src and the checker are compiled first.
*/
`default_nettype none

module alert_enable_masking_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, resetn, rd, wr, waitreq, alert, chain_any, irq;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, q;
  logic [15:0] want, status, chain, pkt;
  int fails = 0;
  int tests_run = 0;

  aem_top dut (.CLK(clk), .RESETN(resetn), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .ALERT_SUMMARY_STATUS(status), .ALERT_OUT(alert),
    .CHAIN_ALERTS(chain), .CHAIN_ALERT_ANY(chain_any),
    .PACKET_ALERTS(pkt), .IRQ(irq));
  aem_status_src src (.clk(clk), .want(want), .status(status));

  ////////////////////////////////////////////////////////////////////////
  // Compare, bus access and status helpers.
  task chk(input string s, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e) begin
      $display("unexpected %s expected %h seen %h", s, e, seen);
      fails++;
    end
  endtask

  // Holds the request until wait request is seen low at an edge.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) fails++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Status needs one edge in the source and one in the block.
  task set(input logic [15:0] v);
    @(posedge clk);
    want <= v;
    repeat (3) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task t_regs;
    bus(0, 8'h64, 0);
    chk("enable reset", q, 32'h3FBF);
    bus(0, 8'h74, 0);
    chk("mask reset", q, 32'h0);
    bus(0, 8'h40, 0);
    chk("unmapped read", q, 32'h0);
    bus(1, 8'h64, 32'hFFFF_FFFF);
    bus(0, 8'h64, 0);
    chk("reserved bits", q, 32'hBFBF);
  endtask

  // One alert at a time against every path.
  task t_paths;
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 16'h0001 << i;
      set(v);
      chk("alert", 32'(alert), 32'((v & 16'hBFBF) != 0));
      chk("chain", 32'(chain), 32'(v & 16'h3F9F));
      chk("packet", 32'(pkt), 32'(v & 16'h3FBF));
    end
    set(16'hFFFF);
    bus(0, 8'h78, 0);
    chk("routed", q, 32'h3FBF_3F9F);
  endtask

  // Enables off leave status readable; scan reaches the pin only.
  task t_mask;
    bus(1, 8'h64, 32'h0);
    set(16'hFFFF);
    chk("masked alert", 32'(alert), 32'h0);
    bus(0, 8'h6C, 0);
    chk("status", q, 32'hFFFF);
    bus(1, 8'h64, 32'h8000);
    set(16'h8000);
    chk("scan alert", 32'(alert), 32'h1);
    chk("scan chain", 32'(chain_any), 32'h0);
  endtask

  // Sticky event, mask and write-one-to-clear.
  task t_irq;
    bus(1, 8'h64, 32'h1);
    bus(1, 8'h70, 32'hFFFF);
    bus(1, 8'h74, 32'h1);
    set(16'h0);
    chk("irq idle", 32'(irq), 32'h0);
    set(16'h1);
    chk("irq set", 32'(irq), 32'h1);
    bus(1, 8'h70, 32'h1);
    @(posedge clk);
    chk("irq clear", 32'(irq), 32'h0);
    bus(1, 8'h74, 32'h0);
    set(16'h0);
    set(16'h1);
    chk("irq masked", 32'(irq), 32'h0);
    bus(0, 8'h70, 0);
    chk("event", q, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task end_of_test;
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Clock of 25 ns.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cuts a hang short well past the expected run.
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    end_of_test;
  end

  // Reset, then the scenarios in turn.
  initial begin
    resetn = 1'b0;
    addr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    be = 4'hF;
    want = 16'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_paths;
    t_mask;
    t_irq;
    end_of_test;
  end
endmodule

`default_nettype wire
